// ===== shared/ssp_defines.vh
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH
// Register byte offsets
`define SSP_OFS_STAT 8'h00
`define SSP_OFS_CTRL 8'h04
`define SSP_OFS_BUF 8'h08
`define SSP_OFS_DIR 8'h0C
`define SSP_OFS_IST 8'h10
`define SSP_OFS_ICLR 8'h14
`define SSP_OFS_IEN 8'h18
// Status register fields
`define SSP_ST_SMP 7
`define SSP_ST_CKE 6
`define SSP_ST_DA 5
`define SSP_ST_P 4
`define SSP_ST_S 3
`define SSP_ST_RW 2
`define SSP_ST_UA 1
`define SSP_ST_BF 0
// Control register fields
`define SSP_CT_MODE 3:0
`define SSP_CT_CKP 4
`define SSP_CT_EN 5
`define SSP_CT_W 6
// Port mode field codes
`define SSP_MD_M4 4'h0
`define SSP_MD_M16 4'h1
`define SSP_MD_M64 4'h2
`define SSP_MD_MTMR 4'h3
`define SSP_MD_SLV_SS 4'h4
`define SSP_MD_SLV 4'h5
// Master half period of the serial clock in system cycles
`define SSP_HALF_M4 8'h04
`define SSP_HALF_M16 8'h08
`define SSP_HALF_M64 8'h20
`define SSP_HALF_MTMR 8'h40
// Direction register
`define SSP_DIR_SDO 4
`define SSP_DIR_RST 8'hFF
// Interrupt bits
`define SSP_IRQ_DONE 0
`define SSP_IRQ_WCOL 1
`define SSP_IRQ_W 2
// Bit count of a word
`define SSP_WORD 8
`endif

// ===== design/ssp_sync2.v
`timescale 1ns/1ps
module ssp_sync2 #(
    parameter W = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Data
    input wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
        end
    end
    assign q = s2_r;
endmodule

// ===== design/ssp_shift.v
`timescale 1ns/1ps
module ssp_shift #(
    parameter W = 8
) (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    input wire clr,
    // Configuration
    input wire cke,
    input wire smp_end,
    // Serial clock events
    input wire lead,
    input wire trail,
    input wire tail,
    // Transmit load
    input wire load,
    input wire [W-1:0] load_data,
    // Serial data
    input wire sdi,
    output wire sdo,
    // Result
    output wire busy,
    output reg done,
    output reg [W-1:0] rx_data
);
    reg [W-1:0] tx_r;
    reg [W-1:0] rx_r;
    reg [3:0] tc_r;
    reg [3:0] rc_r;
    wire tc_nz = (tc_r != 4'h0);
    wire samp = smp_end ? (cke ? trail : ((lead & tc_nz) | tail)) : (cke ? lead : trail);
    wire shift = cke ? trail : (lead & tc_nz);
    wire last = samp & (rc_r == W - 1);
    assign sdo = tx_r[W-1];
    assign busy = tc_nz | (rc_r != 4'h0);
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_r <= {W{1'b0}};
            rx_r <= {W{1'b0}};
            tc_r <= 4'h0;
            rc_r <= 4'h0;
            done <= 1'b0;
            rx_data <= {W{1'b0}};
        end else if (clr) begin
            tc_r <= 4'h0;
            rc_r <= 4'h0;
            done <= 1'b0;
        end else begin
            done <= last;
            if (load)
                tx_r <= load_data;
            else if (shift)
                tx_r <= {tx_r[W-2:0], 1'b0};
            if (trail)
                tc_r <= (tc_r == W - 1) ? 4'h0 : tc_r + 4'h1;
            if (samp) begin
                rx_r <= {rx_r[W-2:0], sdi};
                rc_r <= last ? 4'h0 : rc_r + 4'h1;
            end
            if (last)
                rx_data <= {rx_r[W-2:0], sdi};
        end
    end
endmodule

// ===== design/ssp_top.v
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`include "ssp_defines.vh"
module ssp_top #(
    parameter W = `SSP_WORD
) (
    // System
    input wire CLK_SYS,
    input wire RST_B,
    // AHB-Lite slave
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire HREADY,
    input wire [31:0] HWDATA,
    output reg [31:0] HRDATA,
    output wire HREADYOUT,
    output wire HRESP,
    // SPI pins
    input wire SCK_IN,
    output wire SCK_OUT,
    output wire SCK_OE,
    input wire SDI,
    output wire SDO,
    output wire SDO_OE,
    input wire SS_B,
    // I2C engine events
    input wire I2C_ADDR_MATCH,
    input wire I2C_RW_IN,
    input wire I2C_START,
    input wire I2C_STOP,
    input wire I2C_NACK,
    // Interrupt
    output wire IRQ
);
    reg smp_r;
    reg cke_r;
    reg [`SSP_CT_W-1:0] ctrl_r;
    reg [W-1:0] rxbuf_r;
    reg bf_r;
    reg [7:0] dir_r;
    reg [`SSP_IRQ_W-1:0] ist_r;
    reg [`SSP_IRQ_W-1:0] ien_r;
    reg rw_r;
    reg s_r;
    reg p_r;
    reg dp_wr_r;
    reg [7:0] dp_addr_r;
    reg gen_on_r;
    reg [4:0] idx_r;
    reg [7:0] div_r;
    reg sck_r;
    reg sck_d_r;
    reg [7:0] half;
    reg [31:0] rd_val;
    wire [2:0] pins_s;
    wire sck_s = pins_s[2];
    wire sdi_s = pins_s[1];
    wire ss_hi = pins_s[0];
    wire [3:0] mode = ctrl_r[`SSP_CT_MODE];
    wire ckp = ctrl_r[`SSP_CT_CKP];
    wire en = ctrl_r[`SSP_CT_EN];
    wire spi_md = (mode <= `SSP_MD_SLV);
    wire spi_on = en & spi_md;
    wire i2c_on = en & ~spi_md;
    wire master = spi_on & (mode <= `SSP_MD_MTMR);
    wire ss_ctl = spi_on & (mode == `SSP_MD_SLV_SS);
    wire ss_rst = ss_ctl & ss_hi;
    wire periph_oe = ~ss_rst;
    wire sh_clr = ~spi_on | ss_rst;
    wire smp_eff = smp_r & master;
    wire need_tail = smp_eff & ~cke_r;
    wire tick = gen_on_r & (div_r == half - 8'h01);
    wire m_lead = tick & ~idx_r[4] & ~idx_r[0];
    wire m_trail = tick & ~idx_r[4] & idx_r[0];
    wire m_tail = tick & idx_r[4];
    wire s_rise = sck_s & ~sck_d_r;
    wire s_fall = ~sck_s & sck_d_r;
    wire s_lead = ~master & (ckp ? s_fall : s_rise);
    wire s_trail = ~master & (ckp ? s_rise : s_fall);
    wire sh_busy;
    wire sh_done;
    wire sh_sdo;
    wire [W-1:0] sh_rx;
    wire busy = master ? gen_on_r : sh_busy;
    wire ap = HSEL & HTRANS[1] & HREADY;
    wire ap_rd = ap & ~HWRITE;
    wire wr_ctrl = dp_wr_r & (dp_addr_r == `SSP_OFS_CTRL);
    wire wr_stat = dp_wr_r & (dp_addr_r == `SSP_OFS_STAT);
    wire wr_buf = dp_wr_r & (dp_addr_r == `SSP_OFS_BUF);
    wire wr_dir = dp_wr_r & (dp_addr_r == `SSP_OFS_DIR);
    wire wr_iclr = dp_wr_r & (dp_addr_r == `SSP_OFS_ICLR);
    wire wr_ien = dp_wr_r & (dp_addr_r == `SSP_OFS_IEN);
    wire rd_buf = ap_rd & (HADDR[7:0] == `SSP_OFS_BUF);
    wire load = wr_buf & ~busy & spi_on;
    wire wcol = wr_buf & busy & spi_on;
    wire [`SSP_IRQ_W-1:0] ev = {wcol, sh_done};
    wire [`SSP_IRQ_W-1:0] clr_m = wr_iclr ? HWDATA[`SSP_IRQ_W-1:0] : {`SSP_IRQ_W{1'b0}};
    wire dir_sdo_rd = dir_r[`SSP_DIR_SDO] | ~periph_oe;

    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign IRQ = |(ist_r & ien_r);
    assign SCK_OUT = sck_r;
    assign SCK_OE = master;
    assign SDO = sh_sdo;
    assign SDO_OE = spi_on & ~dir_r[`SSP_DIR_SDO] & periph_oe;

    ssp_sync2 #(
        .W(3),
        .RST_VAL(3'h1)
    ) u_sync (
        .clk(CLK_SYS),
        .rst_b(RST_B),
        .d({SCK_IN, SDI, SS_B}),
        .q(pins_s)
    );

    ssp_shift #(
        .W(W)
    ) u_shift (
        .clk(CLK_SYS),
        .rst_b(RST_B),
        .clr(sh_clr),
        .cke(cke_r),
        .smp_end(smp_eff),
        .lead(m_lead | s_lead),
        .trail(m_trail | s_trail),
        .tail(m_tail),
        .load(load),
        .load_data(HWDATA[W-1:0]),
        .sdi(sdi_s),
        .sdo(sh_sdo),
        .busy(sh_busy),
        .done(sh_done),
        .rx_data(sh_rx)
    );

    // Master half period from the port mode
    always @* begin
        case (mode)
            `SSP_MD_M4: half = `SSP_HALF_M4;
            `SSP_MD_M16: half = `SSP_HALF_M16;
            `SSP_MD_M64: half = `SSP_HALF_M64;
            default: half = `SSP_HALF_MTMR;
        endcase
    end

    // Register read mux
    always @* begin
        rd_val = 32'h0000_0000;
        case (HADDR[7:0])
            `SSP_OFS_STAT: begin
                rd_val[`SSP_ST_SMP] = smp_r;
                rd_val[`SSP_ST_CKE] = cke_r;
                rd_val[`SSP_ST_P] = p_r;
                rd_val[`SSP_ST_S] = s_r;
                rd_val[`SSP_ST_RW] = rw_r;
                rd_val[`SSP_ST_BF] = bf_r;
            end
            `SSP_OFS_CTRL: rd_val[`SSP_CT_W-1:0] = ctrl_r;
            `SSP_OFS_BUF: rd_val[W-1:0] = rxbuf_r;
            `SSP_OFS_DIR: begin
                rd_val[7:0] = dir_r;
                rd_val[`SSP_DIR_SDO] = dir_sdo_rd;
            end
            `SSP_OFS_IST: rd_val[`SSP_IRQ_W-1:0] = ist_r;
            `SSP_OFS_IEN: rd_val[`SSP_IRQ_W-1:0] = ien_r;
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // Bus address phase capture and read data
    always @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            dp_wr_r <= 1'b0;
            dp_addr_r <= 8'h00;
            HRDATA <= 32'h0000_0000;
        end else begin
            dp_wr_r <= ap & HWRITE;
            if (ap)
                dp_addr_r <= HADDR[7:0];
            if (ap_rd)
                HRDATA <= rd_val;
        end
    end

    // Software registers
    always @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            smp_r <= 1'b0;
            cke_r <= 1'b0;
            ctrl_r <= {`SSP_CT_W{1'b0}};
            dir_r <= `SSP_DIR_RST;
            ien_r <= {`SSP_IRQ_W{1'b0}};
        end else begin
            if (wr_stat) begin
                smp_r <= HWDATA[`SSP_ST_SMP];
                cke_r <= HWDATA[`SSP_ST_CKE];
            end
            if (wr_ctrl)
                ctrl_r <= HWDATA[`SSP_CT_W-1:0];
            if (wr_dir)
                dir_r <= HWDATA[7:0];
            if (wr_ien)
                ien_r <= HWDATA[`SSP_IRQ_W-1:0];
        end
    end

    // Receive buffer, buffer full and interrupt status
    always @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            rxbuf_r <= {W{1'b0}};
            bf_r <= 1'b0;
            ist_r <= {`SSP_IRQ_W{1'b0}};
        end else begin
            if (sh_done)
                rxbuf_r <= sh_rx;
            if (sh_done)
                bf_r <= 1'b1;
            else if (rd_buf | ~en)
                bf_r <= 1'b0;
            ist_r <= (ist_r & ~clr_m) | ev;
        end
    end

    // I2C status bits kept while the port is in I2C mode
    always @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            rw_r <= 1'b0;
            s_r <= 1'b0;
            p_r <= 1'b0;
        end else if (!i2c_on) begin
            rw_r <= 1'b0;
            s_r <= 1'b0;
            p_r <= 1'b0;
        end else begin
            if (I2C_ADDR_MATCH)
                rw_r <= I2C_RW_IN;
            else if (I2C_START | I2C_STOP | I2C_NACK)
                rw_r <= 1'b0;
            if (I2C_START) begin
                s_r <= 1'b1;
                p_r <= 1'b0;
            end else if (I2C_STOP) begin
                s_r <= 1'b0;
                p_r <= 1'b1;
            end
        end
    end

    // Master serial clock generator
    always @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            gen_on_r <= 1'b0;
            idx_r <= 5'h00;
            div_r <= 8'h00;
            sck_r <= 1'b0;
        end else if (!master) begin
            gen_on_r <= 1'b0;
            idx_r <= 5'h00;
            div_r <= 8'h00;
            sck_r <= ckp;
        end else if (!gen_on_r) begin
            sck_r <= ckp;
            idx_r <= 5'h00;
            div_r <= 8'h00;
            if (load)
                gen_on_r <= 1'b1;
        end else if (tick) begin
            div_r <= 8'h00;
            idx_r <= idx_r + 5'h01;
            if (!idx_r[4])
                sck_r <= ~sck_r;
            if (idx_r[4] | ((idx_r == 5'h0F) & ~need_tail))
                gen_on_r <= 1'b0;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end

    // Slave serial clock edge detect
    always @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B)
            sck_d_r <= 1'b0;
        else
            sck_d_r <= sck_s;
    end
endmodule

// ===== sim/ssp_top_assertions.sv
`timescale 1ns/1ps
`include "ssp_defines.vh"
module ssp_top_assertions (
    // System
    input wire CLK_SYS,
    input wire RST_B,
    // Bus
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire HREADY,
    input wire [31:0] HWDATA,
    // Pins
    input wire SCK_OUT,
    input wire SCK_OE,
    input wire SDO,
    input wire SDO_OE,
    input wire SS_B,
    input wire IRQ
);
    reg wr_r;
    reg [7:0] wa_r;
    reg [5:0] ctl_r;
    reg dir_r;
    reg cke_r;
    reg [2:0] ien_r;
    wire mst = ctl_r[5] && ctl_r[3:0] < 4'h4;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    // Shadow of the written settings
    always @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            wr_r <= 1'b0;
            wa_r <= 8'h00;
            ctl_r <= 6'h00;
            dir_r <= 1'b1;
            cke_r <= 1'b0;
            ien_r <= 3'h0;
        end else begin
            if (HREADY) begin
                wr_r <= HSEL && HTRANS[1] && HWRITE;
                wa_r <= HADDR[7:0];
            end
            if (wr_r && HREADY) begin
                case (wa_r)
                    `SSP_OFS_CTRL: ctl_r <= HWDATA[5:0];
                    `SSP_OFS_DIR: dir_r <= HWDATA[`SSP_DIR_SDO];
                    `SSP_OFS_STAT: cke_r <= HWDATA[`SSP_ST_CKE];
                    `SSP_OFS_IEN: ien_r <= HWDATA[2:0];
                    default: ;
                endcase
            end
        end
    end
    a_master_clk_on: assert property (mst |-> SCK_OE)
        else $error("clock not driven as master");
    a_slave_clk_off: assert property (ctl_r[5] && !mst |-> !SCK_OE)
        else $error("clock driven outside master");
    a_ss_high_reset: assert property ((ctl_r == 6'h24 && SS_B) [*3] |-> !SDO_OE)
        else $error("data out on with select high");
    a_dir_sdo_off: assert property (dir_r |-> !SDO_OE)
        else $error("data out on with direction off");
    a_i2c_no_sdo: assert property (ctl_r[5] && ctl_r[3:0] > 4'h5 |-> !SDO_OE)
        else $error("data out on in I2C mode");
    a_sdo_lead_stable: assert property (mst && cke_r && !ctl_r[4] && $rose(SCK_OUT)
        |-> $stable(SDO))
        else $error("data out moved on leading edge");
    a_half_period_min: assert property (mst && ctl_r[3:0] == 4'h0 && $changed(SCK_OUT)
        |=> $stable(SCK_OUT))
        else $error("serial clock half period short");
    a_irq_needs_enable: assert property (IRQ |-> ien_r != 3'h0)
        else $error("interrupt with no enable");
endmodule
bind ssp_top ssp_top_assertions ssp_top_assertions_i (
    .CLK_SYS(CLK_SYS), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HREADY(HREADY), .HWDATA(HWDATA), .SCK_OUT(SCK_OUT),
    .SCK_OE(SCK_OE), .SDO(SDO), .SDO_OE(SDO_OE), .SS_B(SS_B), .IRQ(IRQ)
);

// ===== sim/ssp_spi_peer.sv
`timescale 1ns/1ps
module ssp_spi_peer (
    // Serial lines
    input wire sck_m,
    input wire mosi,
    output wire miso,
    output logic sck_s,
    // Control
    input wire ld,
    input wire run,
    input wire [7:0] tx,
    output logic [7:0] rx
);
    logic [7:0] sh = 8'h00;
    logic arm = 1'b0;
    wire sck = sck_m | sck_s;
    initial sck_s = 1'b0;
    initial rx = 8'h00;
    assign miso = sh[7];
    always @(ld) begin
        #1 sh = tx;
        arm = 1'b0;
    end
    // Own clock runs only inside a frame
    always @(run) begin
        repeat (8) begin
            #32 sck_s = 1'b1;
            #32 sck_s = 1'b0;
        end
    end
    always @(posedge sck) begin
        rx <= {rx[6:0], mosi};
        arm <= 1'b1;
    end
    // A fall ahead of the first rise of a frame does not shift
    always @(negedge sck) if (arm) sh <= {sh[6:0], ~sh[0]};
endmodule

// ===== sim/ssp_top_test.sv
`timescale 1ns/1ps
`include "ssp_defines.vh"
module ssp_top_test;
    logic CLK_SYS = 1'b0;
    logic RST_B = 1'b0;
    logic HSEL = 1'b0;
    logic [31:0] HADDR = 32'h0;
    logic [1:0] HTRANS = 2'h0;
    logic HWRITE = 1'b0;
    logic [2:0] HSIZE = 3'h2;
    logic [31:0] HWDATA = 32'h0;
    logic SS_B = 1'b1;
    logic ld = 1'b0;
    logic run = 1'b0;
    logic rd_ph = 1'b0;
    logic [7:0] ptx = 8'h00;
    logic [7:0] mb, sb;
    logic [31:0] st;
    wire [31:0] HRDATA;
    wire HREADYOUT, HRESP, SCK_OUT, SCK_OE, SDO, SDO_OE, IRQ, SDI, SCK_IN;
    wire [7:0] prx;
    logic [31:0] expq[$];
    int fail_count = 0;
    int checks_done = 0;
    int seed = 84891;
    always #2 CLK_SYS = ~CLK_SYS;
    ssp_top ssp_top_i (
        .CLK_SYS(CLK_SYS), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(HSIZE), .HREADY(HREADYOUT), .HWDATA(HWDATA),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SCK_IN(SCK_IN),
        .SCK_OUT(SCK_OUT), .SCK_OE(SCK_OE), .SDI(SDI), .SDO(SDO), .SDO_OE(SDO_OE),
        .SS_B(SS_B), .I2C_ADDR_MATCH(1'b0), .I2C_RW_IN(1'b0), .I2C_START(1'b0),
        .I2C_STOP(1'b0), .I2C_NACK(1'b0), .IRQ(IRQ)
    );
    ssp_spi_peer ssp_spi_peer_i (
        .sck_m(SCK_OUT), .mosi(SDO), .miso(SDI), .sck_s(SCK_IN),
        .ld(ld), .run(run), .tx(ptx), .rx(prx)
    );
    task summarize;
        $display("checks %0d failures %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Single transfer; reads note their expected word
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= {24'h0, a};
        HWRITE <= w;
        do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= w ? d : 32'h0;
        rd_ph <= !w;
        if (!w) expq.push_back(d);
        do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
        rd_ph <= 1'b0;
    endtask
    task wait_irq;
        int n;
        n = 0;
        while (IRQ !== 1'b1 && n < 3000) begin
            @(posedge CLK_SYS);
            n++;
        end
        if (IRQ !== 1'b1) begin
            fail_count++;
            summarize();
        end
    endtask
    always @(posedge CLK_SYS) if (rd_ph) check(HRDATA, expq.pop_front());
    initial begin
        #100000;
        fail_count++;
        summarize();
    end
    initial begin
        repeat (5) @(posedge CLK_SYS);
        RST_B <= 1'b1;
        @(posedge CLK_SYS);
        for (int i = 0; i < 8; i++)
            if (i != 5) bus(1'b0, 8'(4 * i), i == 3 ? 32'hFF : 32'h0);
        bus(1'b1, `SSP_OFS_STAT, 32'hFF);
        bus(1'b0, `SSP_OFS_STAT, 32'hC0);
        bus(1'b1, `SSP_OFS_STAT, 32'h40);
        bus(1'b1, `SSP_OFS_IEN, 32'h1);
        // Each pass: mode m, idle polarity m[0], edge select ~m[0], sample phase m[1]
        for (int m = 0; m < 4; m++) begin
            mb = $random(seed);
            sb = $random(seed);
            st = {24'h0, m[1], ~m[0], 6'h00};
            bus(1'b1, `SSP_OFS_CTRL, {26'h0, 1'b1, m[0], 2'b00, m[1:0]});
            bus(1'b1, `SSP_OFS_STAT, st);
            ptx <= sb;
            ld <= ~ld;
            bus(1'b1, `SSP_OFS_BUF, {24'h0, mb});
            bus(1'b1, `SSP_OFS_BUF, {24'h0, ~mb});
            wait_irq();
            // Let the last clock edge or tail pass before the mode changes
            repeat (70) @(posedge CLK_SYS);
            bus(1'b0, `SSP_OFS_STAT, st | 32'h1);
            bus(1'b0, `SSP_OFS_BUF, {24'h0, sb});
            bus(1'b0, `SSP_OFS_STAT, st);
            check(prx, mb);
            bus(1'b0, `SSP_OFS_IST, 32'h3);
            check(IRQ, 1'b1);
            bus(1'b1, `SSP_OFS_IEN, 32'h0);
            bus(1'b0, `SSP_OFS_IEN, 32'h0);
            check(IRQ, 1'b0);
            bus(1'b1, `SSP_OFS_ICLR, 32'h3);
            bus(1'b1, `SSP_OFS_IEN, 32'h1);
            bus(1'b0, `SSP_OFS_IST, 32'h0);
        end
        SS_B <= 1'b0;
        bus(1'b1, `SSP_OFS_STAT, 32'h40);
        bus(1'b1, `SSP_OFS_CTRL, 32'h24);
        mb = $random(seed);
        sb = $random(seed);
        bus(1'b1, `SSP_OFS_BUF, {24'h0, mb});
        ptx <= sb;
        ld <= ~ld;
        run <= ~run;
        wait_irq();
        bus(1'b0, `SSP_OFS_BUF, {24'h0, sb});
        check(prx, mb);
        bus(1'b1, `SSP_OFS_DIR, 32'h0);
        bus(1'b0, `SSP_OFS_DIR, 32'h0);
        check(SDO_OE, 1'b1);
        SS_B <= 1'b1;
        repeat (4) @(posedge CLK_SYS);
        bus(1'b0, `SSP_OFS_DIR, 32'h10);
        check(SDO_OE, 1'b0);
        bus(1'b1, `SSP_OFS_DIR, 32'h10);
        SS_B <= 1'b0;
        repeat (4) @(posedge CLK_SYS);
        bus(1'b0, `SSP_OFS_DIR, 32'h10);
        check(SDO_OE, 1'b0);
        bus(1'b1, `SSP_OFS_CTRL, 32'h26);
        bus(1'b0, `SSP_OFS_CTRL, 32'h26);
        check(SDO_OE | SCK_OE, 1'b0);
        summarize();
    end
endmodule
